// File: src/ddioc_top.v
// drive digital inputs, up/down reference, pulse reference, counter and output flags
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ddioc_regs.vh"
module ddioc_top #(
  parameter FW        = 16,
  parameter TICK_CYC  = `DDIOC_TICK_PS / `DDIOC_CLK_PS,
  parameter WIN_BITS  = 25
) (
  input  wire          core_clk,
  input  wire          resetn,
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire [5:0]    digital_in,
  input  wire [FW-1:0] output_frequency,
  input  wire          output_voltage_active,
  output reg           relay_output,
  output reg           second_relay_output,
  output reg           transistor_output,
  output reg  [FW-1:0] updown_reference_command,
  output reg  [FW-1:0] pulse_reference
);
  localparam LONG_TICKS = `DDIOC_LONG_MS / `DDIOC_TICK_MS;
  localparam GATE_TICKS = `DDIOC_GATE_MS / `DDIOC_TICK_MS;
  // ************************************
  // reset and input synchronisers
  // ************************************
  reg  [1:0]  rst_sync;
  wire        rst_n = rst_sync[1];
  reg  [5:0]  in_meta;
  reg  [5:0]  in_sync;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta <= 6'h00;
      in_sync <= 6'h00;
    end else begin
      in_meta <= digital_in;
      in_sync <= in_meta;
    end
  end
  // ************************************
  // registers
  // ************************************
  reg  [5:0]    input_polarity_select;
  reg  [FW-1:0] updown_step_size;
  reg  [1:0]    updown_hold_memory_select;
  reg           pulse_input_mode;
  reg           ref_source;
  reg  [9:0]    pulse_input_gain;
  reg  [13:0]   counter_target_value;
  reg  [13:0]   counter_preset_value;
  reg  [3:0]    counter_scan_time;
  reg  [FW-1:0] stored_updown_reference;
  reg  [FW-1:0] frequency_upper_limit;
  reg  [FW-1:0] frequency_lower_limit;
  reg  [FW-1:0] frequency_detect_level;
  reg  [FW-1:0] frequency_agree_width;
  reg  [FW-1:0] ramp_rate;
  reg  [23:0]   output_function_select;
  reg  [13:0]   counter_present_value;
  wire [5:0]    act = in_sync ^ input_polarity_select;
  wire          run = act[0];
  wire          up = act[1];
  wire          down = act[2];
  wire          trig_in = act[3];
  wire          cnt_rst = act[4];
  wire          pulse_in = act[5];
  // ************************************
  // functions
  // ************************************
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction
  function [31:0] zx;
    input [FW-1:0] v;
    begin
      zx = {{(32-FW){1'b0}}, v};
    end
  endfunction
  function [FW-1:0] clamp;
    input [FW:0]   v;
    input [FW-1:0] lo;
    input [FW-1:0] hi;
    begin
      if (v > {1'b0, hi}) begin
        clamp = hi;
      end else if (v < {1'b0, lo}) begin
        clamp = lo;
      end else begin
        clamp = v[FW-1:0];
      end
    end
  endfunction
  function sel_flag;
    input [5:0] fn;
    input [7:0] f;
    begin
      case (fn)
        `DDIOC_FN_RUN:    sel_flag = f[0];
        `DDIOC_FN_AGREE:  sel_flag = f[1];
        `DDIOC_FN_DAGREE: sel_flag = f[2];
        `DDIOC_FN_DET_HI: sel_flag = f[3];
        `DDIOC_FN_DET_LO: sel_flag = f[4];
        `DDIOC_FN_TARGET: sel_flag = f[5];
        `DDIOC_FN_PRESET: sel_flag = f[6];
        `DDIOC_FN_TRIG:   sel_flag = f[7];
        default:          sel_flag = 1'b0;
      endcase
    end
  endfunction
  // ************************************
  // 2 ms tick
  // ************************************
  reg  [31:0] tick_cnt;
  reg         tick;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_CYC - 1);
      tick_cnt <= (tick_cnt == TICK_CYC - 1) ? 32'h0 : tick_cnt + 32'h1;
    end
  end
  // ************************************
  // up/down reference
  // ************************************
  reg           run_d;
  reg           up_d;
  reg           down_d;
  reg  [FW-1:0] ref_target;
  reg  [10:0]   held_ticks;
  reg           store_req;
  wire          ud_en = run | (updown_hold_memory_select == `DDIOC_HOLD_STOPUD);
  wire          step0 = (updown_step_size == {FW{1'b0}});
  wire          cont = step0 | (held_ticks >= LONG_TICKS);
  wire [FW:0]   tgt_up = {1'b0, ref_target} + {1'b0, (cont ? ramp_rate : updown_step_size)};
  wire [FW:0]   tgt_dn = {1'b0, ref_target} - {1'b0, (cont ? ramp_rate : updown_step_size)};
  wire [FW:0]   rf_up = {1'b0, updown_reference_command} + {1'b0, ramp_rate};
  wire [FW:0]   rf_dn = {1'b0, updown_reference_command} - {1'b0, ramp_rate};
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_d <= 1'b0;
      up_d <= 1'b0;
      down_d <= 1'b0;
      ref_target <= {FW{1'b0}};
      held_ticks <= 11'h0;
      store_req <= 1'b0;
      updown_reference_command <= {FW{1'b0}};
    end else begin
      run_d <= run;
      up_d <= up;
      down_d <= down;
      store_req <= run_d & ~run & (updown_hold_memory_select != `DDIOC_HOLD_ZERO);
      if (~(up ^ down)) begin
        held_ticks <= 11'h0;
      end else if (tick && held_ticks < LONG_TICKS) begin
        held_ticks <= held_ticks + 11'h1;
      end
      if (run & ~run_d) begin
        if (updown_hold_memory_select == `DDIOC_HOLD_ZERO) begin
          ref_target <= {FW{1'b0}};
          updown_reference_command <= {FW{1'b0}};
        end else begin
          ref_target <= clamp({1'b0, stored_updown_reference}, frequency_lower_limit, frequency_upper_limit);
        end
      end else if (ud_en && (up ^ down)) begin
        if (cont && tick) begin
          ref_target <= up ? clamp(tgt_up, frequency_lower_limit, frequency_upper_limit)
                           : clamp(tgt_dn[FW] ? {(FW+1){1'b0}} : tgt_dn, frequency_lower_limit,
                                   frequency_upper_limit);
        end else if (!cont && ((up & ~up_d) | (down & ~down_d))) begin
          ref_target <= up ? clamp(tgt_up, frequency_lower_limit, frequency_upper_limit)
                           : clamp(tgt_dn[FW] ? {(FW+1){1'b0}} : tgt_dn, frequency_lower_limit,
                                   frequency_upper_limit);
        end
      end else if (ud_en && cont && (up & down)) begin
        ref_target <= updown_reference_command;
      end else if (ud_en && step0) begin
        ref_target <= updown_reference_command;
      end
      if (tick && !(run & ~run_d)) begin
        if (updown_reference_command < ref_target) begin
          updown_reference_command <= (rf_up > {1'b0, ref_target}) ? ref_target : rf_up[FW-1:0];
        end else if (updown_reference_command > ref_target) begin
          updown_reference_command <= (rf_dn[FW] || rf_dn < {1'b0, ref_target}) ? ref_target : rf_dn[FW-1:0];
        end
      end
    end
  end
  // ************************************
  // pulse reference
  // ************************************
  reg           pin_d;
  reg  [15:0]   hz_cnt;
  reg  [9:0]    gate_ticks;
  reg  [WIN_BITS-1:0] win_cnt;
  reg  [WIN_BITS-1:0] hi_cnt;
  wire [31:0]   f_ref = hz_cnt * pulse_input_gain / `DDIOC_PCT;
  wire [WIN_BITS+FW-1:0] w_prod = hi_cnt * frequency_upper_limit;
  wire [FW-1:0] w_ref = w_prod[WIN_BITS+FW-1:WIN_BITS];
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_d <= 1'b0;
      hz_cnt <= 16'h0;
      gate_ticks <= 10'h0;
      win_cnt <= {WIN_BITS{1'b0}};
      hi_cnt <= {WIN_BITS{1'b0}};
      pulse_reference <= {FW{1'b0}};
    end else begin
      pin_d <= pulse_in;
      if (pulse_input_mode) begin
        if (tick && gate_ticks == GATE_TICKS - 1) begin
          gate_ticks <= 10'h0;
          hz_cnt <= 16'h0;
          pulse_reference <= clamp((f_ref > {16'h0, frequency_upper_limit}) ? {1'b0, frequency_upper_limit}
                                   : f_ref[FW:0], {FW{1'b0}}, frequency_upper_limit);
        end else begin
          if (tick) begin
            gate_ticks <= gate_ticks + 10'h1;
          end
          if (pulse_in & ~pin_d) begin
            hz_cnt <= hz_cnt + 16'h1;
          end
        end
      end else begin
        win_cnt <= win_cnt + {{(WIN_BITS-1){1'b0}}, 1'b1};
        if (&win_cnt) begin
          hi_cnt <= {WIN_BITS{1'b0}};
          pulse_reference <= w_ref;
        end else if (pulse_in) begin
          hi_cnt <= hi_cnt + {{(WIN_BITS-1){1'b0}}, 1'b1};
        end
      end
    end
  end
  // ************************************
  // event counter
  // ************************************
  reg  [3:0]  scan_ticks;
  reg         trig_s;
  reg         hit_target;
  reg         hit_preset;
  wire        scan_now = tick && (scan_ticks + 4'h1 >= counter_scan_time);
  wire [13:0] cnt_nx = counter_present_value + 14'h1;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_ticks <= 4'h0;
      trig_s <= 1'b0;
      counter_present_value <= 14'h0;
      hit_target <= 1'b0;
      hit_preset <= 1'b0;
    end else begin
      if (tick) begin
        scan_ticks <= scan_now ? 4'h0 : scan_ticks + 4'h1;
      end
      if (scan_now) begin
        trig_s <= trig_in;
      end
      if (cnt_rst) begin
        counter_present_value <= 14'h0;
      end else if (scan_now && trig_in && !trig_s) begin
        hit_target <= (cnt_nx == counter_target_value);
        hit_preset <= (cnt_nx == counter_preset_value);
        counter_present_value <= (cnt_nx == counter_target_value) ? 14'h0 : cnt_nx;
      end
    end
  end
  // ************************************
  // output flags
  // ************************************
  wire [FW-1:0] fref = ref_source ? pulse_reference : updown_reference_command;
  wire [FW-1:0] d_ref = (output_frequency > fref) ? output_frequency - fref : fref - output_frequency;
  wire [FW-1:0] d_det = (output_frequency > frequency_detect_level) ? output_frequency - frequency_detect_level
                                                                    : frequency_detect_level - output_frequency;
  wire [7:0]    flags = {trig_s, hit_preset, hit_target,
                         output_frequency <= frequency_detect_level,
                         output_frequency >= frequency_detect_level,
                         d_det <= frequency_agree_width,
                         d_ref <= frequency_agree_width,
                         run | output_voltage_active};
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_output <= 1'b0;
      second_relay_output <= 1'b0;
      transistor_output <= 1'b0;
    end else begin
      relay_output <= sel_flag(output_function_select[5:0], flags);
      second_relay_output <= sel_flag(output_function_select[13:8], flags);
      transistor_output <= sel_flag(output_function_select[21:16], flags);
    end
  end
  // ************************************
  // axi4-lite slave
  // ************************************
  wire        wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  wire [7:0]  wa = s_axi_awaddr;
  function [32:0] reg_word;
    input [7:0] a;
    begin
      reg_word = {1'b1, 32'h0};
      case ({a[7:2], 2'h0})
        `DDIOC_OFS_POL:    reg_word[31:0] = {26'h0, input_polarity_select};
        `DDIOC_OFS_STEP:   reg_word[31:0] = zx(updown_step_size);
        `DDIOC_OFS_HOLD:   reg_word[31:0] = {30'h0, updown_hold_memory_select};
        `DDIOC_OFS_PMODE:  reg_word[31:0] = {30'h0, ref_source, pulse_input_mode};
        `DDIOC_OFS_GAIN:   reg_word[31:0] = {22'h0, pulse_input_gain};
        `DDIOC_OFS_TARGET: reg_word[31:0] = {18'h0, counter_target_value};
        `DDIOC_OFS_PRESET: reg_word[31:0] = {18'h0, counter_preset_value};
        `DDIOC_OFS_SCAN:   reg_word[31:0] = {28'h0, counter_scan_time};
        `DDIOC_OFS_STORED: reg_word[31:0] = zx(stored_updown_reference);
        `DDIOC_OFS_UPPER:  reg_word[31:0] = zx(frequency_upper_limit);
        `DDIOC_OFS_LOWER:  reg_word[31:0] = zx(frequency_lower_limit);
        `DDIOC_OFS_DETECT: reg_word[31:0] = zx(frequency_detect_level);
        `DDIOC_OFS_WIDTH:  reg_word[31:0] = zx(frequency_agree_width);
        `DDIOC_OFS_RATE:   reg_word[31:0] = zx(ramp_rate);
        `DDIOC_OFS_OUTSEL: reg_word[31:0] = {8'h0, output_function_select};
        `DDIOC_OFS_COUNT:  reg_word[31:0] = {18'h0, counter_present_value};
        `DDIOC_OFS_UDREF:  reg_word[31:0] = zx(updown_reference_command);
        `DDIOC_OFS_PREF:   reg_word[31:0] = zx(pulse_reference);
        `DDIOC_OFS_STATUS: reg_word[31:0] = {16'h0, flags, 2'h0, act};
        default:           reg_word[32] = 1'b0;
      endcase
    end
  endfunction
  wire [32:0] rd_word = reg_word(s_axi_araddr);
  wire [32:0] wr_word = reg_word(wa);
  wire [31:0] wdm = merge(wr_word[31:0], s_axi_wdata, s_axi_wstrb);
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DDIOC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `DDIOC_RESP_OKAY;
      s_axi_rdata <= 32'h0;
      input_polarity_select <= 6'h00;
      updown_step_size <= {FW{1'b0}};
      updown_hold_memory_select <= `DDIOC_HOLD_KEEP;
      pulse_input_mode <= 1'b0;
      ref_source <= 1'b0;
      pulse_input_gain <= `DDIOC_RST_GAIN;
      counter_target_value <= 14'h0;
      counter_preset_value <= 14'h0;
      counter_scan_time <= `DDIOC_RST_SCAN;
      stored_updown_reference <= {FW{1'b0}};
      frequency_upper_limit <= `DDIOC_RST_UPPER;
      frequency_lower_limit <= {FW{1'b0}};
      frequency_detect_level <= {FW{1'b0}};
      frequency_agree_width <= {FW{1'b0}};
      ramp_rate <= `DDIOC_RST_RATE;
      output_function_select <= `DDIOC_RST_OUTSEL;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `DDIOC_RESP_OKAY;
        case ({wa[7:2], 2'h0})
          `DDIOC_OFS_POL:    input_polarity_select <= wdm[5:0];
          `DDIOC_OFS_STEP:   updown_step_size <= wdm[FW-1:0];
          `DDIOC_OFS_HOLD:   updown_hold_memory_select <= wdm[1:0];
          `DDIOC_OFS_PMODE:  {ref_source, pulse_input_mode} <= wdm[1:0];
          `DDIOC_OFS_GAIN:   pulse_input_gain <= wdm[9:0];
          `DDIOC_OFS_TARGET: counter_target_value <= wdm[13:0];
          `DDIOC_OFS_PRESET: counter_preset_value <= wdm[13:0];
          `DDIOC_OFS_SCAN:   counter_scan_time <= wdm[3:0];
          `DDIOC_OFS_STORED: stored_updown_reference <= wdm[FW-1:0];
          `DDIOC_OFS_UPPER:  frequency_upper_limit <= wdm[FW-1:0];
          `DDIOC_OFS_LOWER:  frequency_lower_limit <= wdm[FW-1:0];
          `DDIOC_OFS_DETECT: frequency_detect_level <= wdm[FW-1:0];
          `DDIOC_OFS_WIDTH:  frequency_agree_width <= wdm[FW-1:0];
          `DDIOC_OFS_RATE:   ramp_rate <= wdm[FW-1:0];
          `DDIOC_OFS_OUTSEL: output_function_select <= wdm[23:0];
          `DDIOC_OFS_COUNT, `DDIOC_OFS_UDREF, `DDIOC_OFS_PREF, `DDIOC_OFS_STATUS: s_axi_bresp <= `DDIOC_RESP_OKAY;
          default:           s_axi_bresp <= `DDIOC_RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (store_req) begin
        stored_updown_reference <= updown_reference_command;
      end
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word[31:0];
        s_axi_rresp <= rd_word[32] ? `DDIOC_RESP_OKAY : `DDIOC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: src/ddioc_regs.vh
// register map, field layout and timing constants of the drive digital io block
`ifndef DDIOC_REGS_VH
`define DDIOC_REGS_VH
// ************************************
// register byte offsets
// ************************************
`define DDIOC_OFS_POL     8'h00
`define DDIOC_OFS_STEP    8'h04
`define DDIOC_OFS_HOLD    8'h08
`define DDIOC_OFS_PMODE   8'h0C
`define DDIOC_OFS_GAIN    8'h10
`define DDIOC_OFS_TARGET  8'h14
`define DDIOC_OFS_PRESET  8'h18
`define DDIOC_OFS_SCAN    8'h1C
`define DDIOC_OFS_STORED  8'h20
`define DDIOC_OFS_UPPER   8'h24
`define DDIOC_OFS_LOWER   8'h28
`define DDIOC_OFS_DETECT  8'h2C
`define DDIOC_OFS_WIDTH   8'h30
`define DDIOC_OFS_RATE    8'h34
`define DDIOC_OFS_OUTSEL  8'h38
`define DDIOC_OFS_COUNT   8'h40
`define DDIOC_OFS_UDREF   8'h44
`define DDIOC_OFS_PREF    8'h48
`define DDIOC_OFS_STATUS  8'h4C
// ************************************
// reset values
// ************************************
`define DDIOC_RST_GAIN    10'h064
`define DDIOC_RST_SCAN    4'h1
`define DDIOC_RST_UPPER   16'h1770
`define DDIOC_RST_RATE    16'h0001
`define DDIOC_RST_OUTSEL  24'h020000
// ************************************
// encodings
// ************************************
`define DDIOC_HOLD_KEEP   2'h0
`define DDIOC_HOLD_ZERO   2'h1
`define DDIOC_HOLD_STOPUD 2'h2
`define DDIOC_FN_RUN      6'h00
`define DDIOC_FN_AGREE    6'h02
`define DDIOC_FN_DAGREE   6'h03
`define DDIOC_FN_DET_HI   6'h04
`define DDIOC_FN_DET_LO   6'h05
`define DDIOC_FN_TARGET   6'h2E
`define DDIOC_FN_PRESET   6'h2F
`define DDIOC_FN_TRIG     6'h30
`define DDIOC_RESP_OKAY   2'h0
`define DDIOC_RESP_SLVERR 2'h2
// ************************************
// timing
// ************************************
`define DDIOC_CLK_PS      4000
`define DDIOC_TICK_PS     2000000000
`define DDIOC_LONG_MS     2000
`define DDIOC_GATE_MS     1000
`define DDIOC_TICK_MS     2
`define DDIOC_PCT         100
`endif

// File: tb/ddioc_sva.sv
// handshake checker for the register bus of the digital io block
`timescale 1ns/1ps
module ddioc_sva (
  input wire        core_clk,
  input wire        resetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_wvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence wr_req;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  endsequence
  sequence rd_req;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  a_write_taken: assert property (wr_req |=> s_axi_awready && s_axi_bvalid)
    else $error("write not answered");
  a_ready_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("awready and wready differ");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_b_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid not released");
  a_read_taken: assert property (rd_req |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  a_r_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule
bind ddioc_top ddioc_sva u_ddioc_sva (.core_clk, .resetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata);

// File: tb/ddioc_field.sv
// contact and pulse generator model for the input terminals
`timescale 1ns/1ps
module ddioc_field (
  input  wire  core_clk,
  output logic trig_pin,
  output logic pwm_pin
);
  int ph = 0;
  initial begin
    trig_pin = 1'b0;
    pwm_pin  = 1'b0;
  end
  // pwm period 40 cycles, 10 high
  always @(posedge core_clk) begin
    ph      <= (ph == 39) ? 0 : ph + 1;
    pwm_pin <= (ph < 10);
  end
  // trigger pulses, 100 cycles period
  task automatic pulses(input int n);
    repeat (n) begin
      trig_pin <= 1'b1;
      repeat (50) @(posedge core_clk);
      trig_pin <= 1'b0;
      repeat (50) @(posedge core_clk);
    end
  endtask
endmodule

// File: tb/ddioc_top_tb.sv
// self-checking bench for the digital io block
`timescale 1ns/1ps
`include "ddioc_regs.vh"
module ddioc_top_tb;
  logic        core_clk = 0, resetn = 0, awv = 0, wv = 0, bv, br = 0, arv = 0, rv_, rr = 0, volt = 0;
  logic [3:0]  ws = 4'hF;
  logic        awr, wrd, arr, rly, rly2, tro, trig, pwm;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, rv;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] freq = 0, udref, pref, r1;
  logic [4:0]  pin = 0;
  int          fails = 0, n_checks = 0;
  logic [7:0]  ofs [7] = '{`DDIOC_OFS_GAIN, `DDIOC_OFS_SCAN, `DDIOC_OFS_UPPER, `DDIOC_OFS_OUTSEL,
                          `DDIOC_OFS_TARGET, `DDIOC_OFS_PRESET, `DDIOC_OFS_RATE};
  logic [31:0] dfl [7] = '{32'h64, 32'h1, 32'h1770, 32'h20000, 32'h0, 32'h0, 32'h1};
  logic [15:0] fq [4] = '{16'h1000, 16'h1010, 16'h1011, 16'h0FEF};
  ddioc_top #(.TICK_CYC(20), .WIN_BITS(8)) u_ddioc_top (.core_clk(core_clk), .resetn(resetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv_), .s_axi_rready(rr), .digital_in({pwm, pin[4], trig, pin[2:0]}),
    .output_frequency(freq), .output_voltage_active(volt), .relay_output(rly), .second_relay_output(rly2),
    .transistor_output(tro), .updown_reference_command(udref), .pulse_reference(pref));
  ddioc_field u_ddioc_field (.core_clk(core_clk), .trig_pin(trig), .pwm_pin(pwm));
  always #2 core_clk = ~core_clk;
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task ck(input string n, input [31:0] e, input [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge core_clk);
    awa <= a;
    wd  <= d;
    awv <= 1;
    wv  <= 1;
    br  <= 1;
    do @(posedge core_clk); while (!awr);
    awv <= 0;
    wv  <= 0;
    while (!bv) @(posedge core_clk);
    br <= 0;
  endtask
  task rd(input [7:0] a);
    @(posedge core_clk);
    ara <= a;
    arv <= 1;
    rr  <= 1;
    do @(posedge core_clk); while (!arr);
    arv <= 0;
    while (!rv_) @(posedge core_clk);
    rv = rdat;
    rs = rresp;
    rr <= 0;
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    summarize;
  end
  initial begin
    cyc(5);
    resetn <= 1;
    cyc(4);
    foreach (ofs[i]) begin
      rd(ofs[i]);
      ck("reset value", dfl[i], rv);
    end
    rd(8'h3C);
    ck("unmapped resp", `DDIOC_RESP_SLVERR, rs);
    ck("run flag idle", 0, rly);
    wr(`DDIOC_OFS_POL, 1);
    cyc(8);
    rd(`DDIOC_OFS_STATUS);
    ck("open contact active", 1, rv[4:0]);
    ck("run flag", 1, rly);
    wr(`DDIOC_OFS_POL, 0);
    volt <= 1;
    cyc(8);
    ck("voltage flag", 1, rly);
    rd(`DDIOC_OFS_STATUS);
    ck("closed contact active", 0, rv[4:0]);
    volt <= 0;
    wr(`DDIOC_OFS_RATE, 16);
    pin[0] <= 1;
    cyc(8);
    pin[1] <= 1;
    cyc(200);
    pin[1] <= 0;
    cyc(60);
    r1 = udref;
    ck("ramp rate", 1, r1 >= 96 && r1 <= 208);
    cyc(100);
    ck("reference held", r1, udref);
    pin[0] <= 0;
    cyc(20);
    pin[1] <= 1;
    cyc(100);
    pin[1] <= 0;
    rd(`DDIOC_OFS_STORED);
    ck("stored reference", r1, rv);
    ck("stopped up ignored", r1, udref);
    wr(`DDIOC_OFS_HOLD, 1);
    pin[0] <= 1;
    cyc(20);
    ck("restart at zero", 0, udref);
    wr(`DDIOC_OFS_STEP, 100);
    pin[1] <= 1;
    cyc(30);
    pin[1] <= 0;
    cyc(200);
    ck("one step up", 100, udref);
    pin[2] <= 1;
    cyc(30);
    pin[2] <= 0;
    cyc(200);
    ck("one step down", 0, udref);
    pin[0] <= 0;
    cyc(8);
    rd(`DDIOC_OFS_STORED);
    ck("no store", r1, rv);
    ws <= 4'h1;
    wr(`DDIOC_OFS_TARGET, 32'hFF03);
    ws <= 4'hF;
    rd(`DDIOC_OFS_TARGET);
    ck("byte strobe", 3, rv);
    wr(`DDIOC_OFS_PRESET, 2);
    wr(`DDIOC_OFS_OUTSEL, 32'h2E2F00);
    u_ddioc_field.pulses(2);
    rd(`DDIOC_OFS_COUNT);
    ck("count", 2, rv);
    ck("preset flag", 1, rly2);
    u_ddioc_field.pulses(1);
    rd(`DDIOC_OFS_COUNT);
    ck("count at target", 0, rv);
    ck("target flag", 1, tro);
    ck("preset flag clear", 0, rly2);
    u_ddioc_field.pulses(1);
    ck("target flag clear", 0, tro);
    pin[4] <= 1;
    u_ddioc_field.pulses(1);
    rd(`DDIOC_OFS_COUNT);
    ck("count held", 0, rv);
    pin[4] <= 0;
    wr(`DDIOC_OFS_OUTSEL, 32'h300000);
    fork
      u_ddioc_field.pulses(1);
      begin
        cyc(40);
        ck("trigger level", 1, tro);
      end
    join
    ck("trigger released", 0, tro);
    wr(`DDIOC_OFS_DETECT, 32'h1000);
    wr(`DDIOC_OFS_WIDTH, 32'h10);
    wr(`DDIOC_OFS_OUTSEL, 32'h030504);
    foreach (fq[i]) begin
      freq <= fq[i];
      cyc(6);
      ck("at or above", fq[i] >= 16'h1000, rly);
      ck("at or below", fq[i] <= 16'h1000, rly2);
      ck("near level", fq[i] >= 16'h0FF0 && fq[i] <= 16'h1010, tro);
    end
    wr(`DDIOC_OFS_OUTSEL, 32'h2);
    freq <= 16'h10;
    cyc(6);
    ck("agree", 1, rly);
    freq <= 16'h11;
    cyc(6);
    ck("not agree", 0, rly);
    ck("width reference", 1, pref > 1300 && pref < 1700);
    wr(`DDIOC_OFS_HOLD, 2);
    wr(`DDIOC_OFS_GAIN, 200);
    wr(`DDIOC_OFS_PMODE, 1);
    pin[1] <= 1;
    cyc(21000);
    ck("long press ramps", 1, udref > 500 && udref < 1000);
    ck("pulse frequency", 1, pref >= 498 && pref <= 500);
    summarize;
  end
endmodule
